// File: rtl/event_status_and_system_mode.sv
/*
  Event status and system mode block: interrupt source flags, FIFO trigger
  gating, FIFO gate error timing and operating mode report.
  Assumes the serial engine gives one-cycle read and write strobes with the
  register address, and that detection functions give qualified event levels.
*/
// Behaviour
// - trigger bit 3 enables pulse gating
// - trigger bit 2 enables free-fall/motion gating
// - trigger bit 1 enables vector-magnitude gating
// - enabled flag among bits 5..1 in trigger mode stops FIFO
// - gate error sets mode bit 7
// - empty FIFO clears gate error
// - bits 6..2 count data periods since error
// - bits 1..0 report standby, wake, sleep
// - source bit shows function interrupt state
// - source read clears only vector-magnitude flag
// - other flags except data-ready clear by own status read
// - bit 7 set on sleep/wake event
// - long inactivity moves wake to sleep
// - wake event moves sleep to wake
// - mode register read clears sleep/wake flag
// - bit 6 set on FIFO event
// - FIFO status read clears FIFO flag
// - bit 5 set on transient event
// - transient source read clears transient flag
// - data-ready clears after X, Y, Z reads
`timescale 1ns/1ns
`include "evt_params.svh"

module event_status_and_system_mode
    import evt_pkg::*;
(
    input  wire logic       i_clock,          // sample-rate clock, 10 MHz
    input  wire logic       i_rst_b,          // async reset, active low
    input  wire logic [7:0] i_reg_addr,       // register address
    input  wire logic       i_reg_rd,         // read strobe, one cycle
    input  wire logic       i_reg_wr,         // write strobe, one cycle
    input  wire logic [7:0] i_reg_wdata,      // write data
    output logic      [7:0] o_reg_rdata,      // read data, registered
    output logic            o_reg_hit,        // read hit this block
    input  wire logic       i_evt_drdy,       // new x/y/z set ready
    input  wire logic       i_evt_vecm,       // vector-magnitude event
    input  wire logic       i_evt_ffmt,       // free-fall/motion event
    input  wire logic       i_evt_pulse,      // pulse event
    input  wire logic       i_evt_orient,     // orientation event
    input  wire logic       i_evt_trans,      // transient event
    input  wire logic       i_evt_fifo,       // overflow or watermark
    input  wire logic       i_fifo_trig_mode, // FIFO in trigger mode
    input  wire logic       i_fifo_empty,     // FIFO holds no sample
    input  wire logic       i_gate_err,       // gate error detected
    input  wire logic       i_odr_tick,       // one pulse per data period
    input  wire logic       i_active,         // active mode selected
    input  wire logic       i_inact_expired,  // inactivity past limit
    input  wire logic       i_wake_evt,       // selected wake event
    output logic            o_fifo_gate,      // stop FIFO collection
    output logic            o_odr_low,        // use the sleep data rate
    output logic      [1:0] o_sys_mode        // current operating mode
);

    function automatic logic rd_at(
        input logic [7:0] addr,
        input logic       rd,
        input logic [7:0] target
    );
        rd_at = rd && (addr == target);
    endfunction : rd_at

    mode_if mif ();

    mode_tracker u_mode (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .mif     (mif.tracker)
    );

    assign mif.active        = i_active;
    assign mif.inact_expired = i_inact_expired;
    assign mif.wake_evt      = i_wake_evt;

    reg_byte_t trig_cfg_reg;
    reg_byte_t flag_reg;
    reg_byte_t flag_next;
    reg_byte_t evt_in;
    reg_byte_t clr_in;
    logic      fgerr_reg;
    logic      fgerr_next;
    logic [4:0] fgt_reg;
    logic [2:0] seen_reg;
    logic [2:0] seen_now;
    logic      xyz_done;
    logic      gate_reg;
    logic      trig_hit;
    reg_byte_t sys_mode_val;
    reg_byte_t rdata_reg;
    logic      hit_reg;
    logic      rd_src;
    logic      rd_sys;
    logic      rd_fifo;
    logic      rd_trans;

    assign rd_src   = rd_at(i_reg_addr, i_reg_rd, `ADDR_INT_SRC);
    assign rd_sys   = rd_at(i_reg_addr, i_reg_rd, `ADDR_SYS_MODE);
    assign rd_fifo  = rd_at(i_reg_addr, i_reg_rd, `ADDR_FIFO_STATUS);
    assign rd_trans = rd_at(i_reg_addr, i_reg_rd, `ADDR_TRANS_SRC);

    // trigger configuration: every bit is read/write
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trig_cfg_reg <= `TRIG_CFG_RST;
        end else if (i_reg_wr && i_reg_addr == `ADDR_TRIG_CFG) begin
            trig_cfg_reg <= i_reg_wdata;
        end
    end

    // data-ready needs all three high-byte reads, in any order
    assign seen_now = seen_reg | {
        rd_at(i_reg_addr, i_reg_rd, `ADDR_OUT_Z_HI),
        rd_at(i_reg_addr, i_reg_rd, `ADDR_OUT_Y_HI),
        rd_at(i_reg_addr, i_reg_rd, `ADDR_OUT_X_HI)};
    assign xyz_done = &seen_now;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seen_reg <= 3'h0;
        end else if (xyz_done || !flag_reg[`SRC_DRDY]) begin
            seen_reg <= 3'h0;
        end else begin
            seen_reg <= seen_now;
        end
    end

    always_comb begin
        evt_in              = 8'h00;
        evt_in[`SRC_DRDY]   = i_evt_drdy;
        evt_in[`SRC_VECM]   = i_evt_vecm;
        evt_in[`SRC_FFMT]   = i_evt_ffmt;
        evt_in[`SRC_PULSE]  = i_evt_pulse;
        evt_in[`SRC_ORIENT] = i_evt_orient;
        evt_in[`SRC_TRANS]  = i_evt_trans;
        evt_in[`SRC_FIFO]   = i_evt_fifo;
        evt_in[`SRC_ASLP]   = mif.trans_evt;
    end

    always_comb begin
        clr_in              = 8'h00;
        clr_in[`SRC_DRDY]   = xyz_done;
        clr_in[`SRC_VECM]   = rd_src;
        clr_in[`SRC_FFMT]   = rd_at(i_reg_addr, i_reg_rd, `ADDR_FFMT_SRC);
        clr_in[`SRC_PULSE]  = rd_at(i_reg_addr, i_reg_rd, `ADDR_PULSE_SRC);
        clr_in[`SRC_ORIENT] = rd_at(i_reg_addr, i_reg_rd, `ADDR_ORIENT_STAT);
        clr_in[`SRC_TRANS]  = rd_trans;
        clr_in[`SRC_FIFO]   = rd_fifo;
        clr_in[`SRC_ASLP]   = rd_sys;
    end

    // an event in the clearing cycle survives: set wins over clear
    for (genvar i = 0; i < 8; i++) begin : g_flag
        assign flag_next[i] = evt_in[i] | (flag_reg[i] & ~clr_in[i]);
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            flag_reg <= `INT_SRC_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // gating is taken from the next flag value so it lands on the event edge;
    // it holds until trigger mode is left, keeping the pre-event samples
    assign trig_hit = |(trig_cfg_reg & flag_next & `TRIG_SRC_MASK);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gate_reg <= 1'b0;
        end else begin
            gate_reg <= i_fifo_trig_mode && (gate_reg || trig_hit);
        end
    end

    assign fgerr_next = i_gate_err || (fgerr_reg && !i_fifo_empty);

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fgerr_reg <= 1'b0;
        end else begin
            fgerr_reg <= fgerr_next;
        end
    end

    // the period count saturates rather than wrapping back to a small age
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fgt_reg <= 5'h00;
        end else if (!fgerr_next) begin
            fgt_reg <= 5'h00;
        end else if (fgerr_reg && i_odr_tick && fgt_reg != `FGT_MAX) begin
            fgt_reg <= fgt_reg + 5'h01;
        end
    end

    always_comb begin
        sys_mode_val                     = 8'h00;
        sys_mode_val[`FGERR_BIT]         = fgerr_reg;
        sys_mode_val[`FGT_MSB:`FGT_LSB]  = fgt_reg;
        sys_mode_val[1:0]                = mif.mode;
    end

    // read data shows the value before any clear caused by that read
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_reg <= 8'h00;
            hit_reg   <= 1'b0;
        end else if (i_reg_rd) begin
            hit_reg <= 1'b1;
            unique case (i_reg_addr)
                `ADDR_TRIG_CFG: rdata_reg <= trig_cfg_reg;
                `ADDR_SYS_MODE: rdata_reg <= sys_mode_val;
                `ADDR_INT_SRC:  rdata_reg <= flag_reg;
                default: begin
                    rdata_reg <= 8'h00;
                    hit_reg   <= 1'b0;
                end
            endcase
        end else begin
            hit_reg <= 1'b0;
        end
    end

    assign o_reg_rdata = rdata_reg;
    assign o_reg_hit   = hit_reg;
    assign o_fifo_gate = gate_reg;
    assign o_odr_low   = (mif.mode == SYS_SLEEP);
    assign o_sys_mode  = mif.mode;

    sequence s_src_read_clean;
        rd_src && !i_evt_vecm;
    endsequence

    sequence s_pulse_armed;
        i_fifo_trig_mode && trig_cfg_reg[`SRC_PULSE] && i_evt_pulse;
    endsequence

    property p_vecm_read_clear;
        @(posedge i_clock) disable iff (!i_rst_b)
        s_src_read_clean |=> !flag_reg[`SRC_VECM];
    endproperty
    a_vecm_read_clear: assert property (p_vecm_read_clear)
        else $error("source read left vector flag set");

    property p_src_read_keeps;
        @(posedge i_clock) disable iff (!i_rst_b)
        rd_src && flag_reg[`SRC_FFMT] |=> flag_reg[`SRC_FFMT];
    endproperty
    a_src_read_keeps: assert property (p_src_read_keeps)
        else $error("source read cleared motion flag");

    property p_pulse_gate;
        @(posedge i_clock) disable iff (!i_rst_b)
        s_pulse_armed ##0 i_fifo_trig_mode |=> o_fifo_gate;
    endproperty
    a_pulse_gate: assert property (p_pulse_gate)
        else $error("pulse trigger did not gate FIFO");

    property p_fgerr_set;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_gate_err |=> fgerr_reg;
    endproperty
    a_fgerr_set: assert property (p_fgerr_set)
        else $error("gate error not flagged");

    property p_fgerr_clear;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_fifo_empty && !i_gate_err |=> !fgerr_reg && fgt_reg == 5'h00;
    endproperty
    a_fgerr_clear: assert property (p_fgerr_clear)
        else $error("empty FIFO left gate error");

    property p_fgt_count;
        @(posedge i_clock) disable iff (!i_rst_b)
        fgerr_reg && !i_fifo_empty && i_odr_tick && fgt_reg < 5'h1F
            |=> fgt_reg == $past(fgt_reg) + 5'h01;
    endproperty
    a_fgt_count: assert property (p_fgt_count)
        else $error("period count did not advance");

    property p_aslp_clear;
        @(posedge i_clock) disable iff (!i_rst_b)
        rd_sys && !mif.trans_evt |=> !flag_reg[`SRC_ASLP];
    endproperty
    a_aslp_clear: assert property (p_aslp_clear)
        else $error("mode read left sleep flag");

    property p_aslp_set;
        @(posedge i_clock) disable iff (!i_rst_b)
        mif.trans_evt |=> flag_reg[`SRC_ASLP] && o_sys_mode != $past(o_sys_mode);
    endproperty
    a_aslp_set: assert property (p_aslp_set)
        else $error("mode change without sleep flag");

    property p_fifo_clear;
        @(posedge i_clock) disable iff (!i_rst_b)
        rd_fifo && !i_evt_fifo |=> !flag_reg[`SRC_FIFO];
    endproperty
    a_fifo_clear: assert property (p_fifo_clear)
        else $error("status read left FIFO flag");

    property p_trans_cycle;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_evt_trans ##1 (rd_trans && !i_evt_trans) |=> !flag_reg[`SRC_TRANS];
    endproperty
    a_trans_cycle: assert property (p_trans_cycle)
        else $error("transient flag set/clear wrong");

    property p_drdy_clear;
        @(posedge i_clock) disable iff (!i_rst_b)
        flag_reg[`SRC_DRDY] && xyz_done && !i_evt_drdy |=> !flag_reg[`SRC_DRDY];
    endproperty
    a_drdy_clear: assert property (p_drdy_clear)
        else $error("xyz reads left data-ready");

    property p_drdy_hold;
        @(posedge i_clock) disable iff (!i_rst_b)
        flag_reg[`SRC_DRDY] && !xyz_done |=> flag_reg[`SRC_DRDY];
    endproperty
    a_drdy_hold: assert property (p_drdy_hold)
        else $error("data-ready cleared before all axes read");

    property p_gate_release;
        @(posedge i_clock) disable iff (!i_rst_b)
        !i_fifo_trig_mode |=> !o_fifo_gate;
    endproperty
    a_gate_release: assert property (p_gate_release)
        else $error("FIFO gate held outside trigger mode");

    property p_fgt_idle;
        @(posedge i_clock) disable iff (!i_rst_b)
        !fgerr_reg |-> fgt_reg == 5'h00;
    endproperty
    a_fgt_idle: assert property (p_fgt_idle)
        else $error("period count set without gate error");

    property p_standby_mode;
        @(posedge i_clock) disable iff (!i_rst_b)
        !i_active |=> o_sys_mode == `MODE_STANDBY;
    endproperty
    a_standby_mode: assert property (p_standby_mode)
        else $error("mode not standby while inactive");

endmodule : event_status_and_system_mode

// File: rtl/evt_params.svh
/*
  Constants of the event status and system mode block: register offsets,
  bit positions, reset values and mode codes.
  Assumes 8-bit register addresses and data on the serial register port.
*/
`ifndef EVT_PARAMS_SVH
`define EVT_PARAMS_SVH

`define ADDR_FIFO_STATUS  8'h00
`define ADDR_OUT_X_HI     8'h01
`define ADDR_OUT_Y_HI     8'h03
`define ADDR_OUT_Z_HI     8'h05
`define ADDR_TRIG_CFG     8'h0A
`define ADDR_SYS_MODE     8'h0B
`define ADDR_INT_SRC      8'h0C
`define ADDR_ORIENT_STAT  8'h30
`define ADDR_FFMT_SRC     8'h31
`define ADDR_TRANS_SRC    8'h32
`define ADDR_PULSE_SRC    8'h33

`define SRC_DRDY          0
`define SRC_VECM          1
`define SRC_FFMT          2
`define SRC_PULSE         3
`define SRC_ORIENT        4
`define SRC_TRANS         5
`define SRC_FIFO          6
`define SRC_ASLP          7

`define TRIG_SRC_MASK     8'h3E
`define TRIG_CFG_RST      8'h00
`define INT_SRC_RST       8'h00

`define FGERR_BIT         7
`define FGT_MSB           6
`define FGT_LSB           2
`define FGT_MAX           5'h1F

`define MODE_STANDBY      2'h0
`define MODE_WAKE         2'h1
`define MODE_SLEEP        2'h2

`endif

// File: rtl/evt_pkg.sv
/*
  Types shared by the event status block and its mode tracker.
  Assumes evt_params.svh is on the include path.
*/
`include "evt_params.svh"

package evt_pkg;
    typedef enum logic [1:0] {
        SYS_STANDBY = `MODE_STANDBY,
        SYS_WAKE    = `MODE_WAKE,
        SYS_SLEEP   = `MODE_SLEEP
    } sys_mode_t;

    typedef logic [7:0] reg_byte_t;
endpackage : evt_pkg

// File: rtl/mode_if.sv
/*
  Carrier between the status block and the mode tracker.
  Assumes both ends share i_clock.
*/
`timescale 1ns/1ns

interface mode_if;
    import evt_pkg::*;
    logic      active;
    logic      inact_expired;
    logic      wake_evt;
    sys_mode_t mode;
    logic      trans_evt;

    modport tracker (
        input  active, inact_expired, wake_evt,
        output mode, trans_evt
    );
    modport user (
        output active, inact_expired, wake_evt,
        input  mode, trans_evt
    );
endinterface : mode_if

// File: rtl/mode_tracker.sv
/*
  Standby / wake / sleep tracker with its transition event.
  Assumes inactivity expiry and wake events are already qualified upstream.
*/
`timescale 1ns/1ns

module mode_tracker
    import evt_pkg::*;
(
    input wire logic i_clock,   // sample-rate clock
    input wire logic i_rst_b,   // async reset, active low
    mode_if.tracker  mif        // mode control and report
);

    sys_mode_t mode_reg;
    sys_mode_t mode_next;
    logic      trans;

    // transition event is combinational so flag and mode move on one edge
    always_comb begin
        mode_next = mode_reg;
        trans     = 1'b0;
        if (!mif.active) begin
            mode_next = SYS_STANDBY;
        end else begin
            unique case (mode_reg)
                SYS_STANDBY: mode_next = SYS_WAKE;
                SYS_WAKE: begin
                    if (mif.inact_expired) begin
                        mode_next = SYS_SLEEP;
                        trans     = 1'b1;
                    end
                end
                SYS_SLEEP: begin
                    if (mif.wake_evt) begin
                        mode_next = SYS_WAKE;
                        trans     = 1'b1;
                    end
                end
                default: mode_next = SYS_STANDBY;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_reg <= SYS_STANDBY;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign mif.mode      = mode_reg;
    assign mif.trans_evt = trans;

    sequence s_go_sleep;
        mif.active && mode_reg == SYS_WAKE && mif.inact_expired;
    endsequence

    sequence s_go_wake;
        mif.active && mode_reg == SYS_SLEEP && mif.wake_evt;
    endsequence

    property p_wake_to_sleep;
        @(posedge i_clock) disable iff (!i_rst_b)
        s_go_sleep |=> mode_reg == SYS_SLEEP;
    endproperty
    a_wake_to_sleep: assert property (p_wake_to_sleep)
        else $error("wake did not fall to sleep");

    property p_sleep_to_wake;
        @(posedge i_clock) disable iff (!i_rst_b)
        s_go_wake |=> mode_reg == SYS_WAKE;
    endproperty
    a_sleep_to_wake: assert property (p_sleep_to_wake)
        else $error("sleep did not return to wake");

endmodule : mode_tracker

// File: verification/host_model.sv
/*
  Host side of the register port: one-cycle read and write strobes.
  Assumes the bench supplies the clock and calls the tasks only after reset.
*/
`timescale 1ns/1ns

module host_model (
    input  wire logic       i_clock, // sample-rate clock
    input  wire logic [7:0] i_rdata, // read data from the block
    input  wire logic       i_hit,   // read hit from the block
    output logic      [7:0] o_addr,  // register address
    output logic            o_rd,    // read strobe
    output logic            o_wr,    // write strobe
    output logic      [7:0] o_wdata  // write data
);
    initial begin
        o_addr  = 8'hFF;
        o_rd    = 1'b0;
        o_wr    = 1'b0;
        o_wdata = 8'hA5;
    end

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clock);
        o_wr    <= 1'b0;
        // released lines carry junk so a stale value is never mistaken for a request
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask : reg_write

    // read data is registered, so it is taken just after the strobe's edge
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(posedge i_clock);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clock);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
        h = i_hit;
    endtask : reg_read
endmodule : host_model

// File: verification/event_status_and_system_mode_bench.sv
/*
  Self-checking bench of the event status and system mode block.
  Assumes host_model drives the register port; pulses are one cycle wide.
*/
`timescale 1ns/1ns
`include "evt_params.svh"
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end

module event_status_and_system_mode_bench;
    logic        clock;
    logic        rst_b;
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        hit;
    logic [11:0] pulse_vec; // 0..6 events, 7 gate error, 8 tick, 9 inactivity, 10 wake, 11 empty
    logic        trig_mode;
    logic        active;
    logic        fifo_gate;
    logic        odr_low;
    logic [1:0]  sys_mode;
    int          n_fail;
    int          samples_checked;

    event_status_and_system_mode u_dut (
        .i_clock(clock), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit),
        .i_evt_drdy(pulse_vec[0]), .i_evt_vecm(pulse_vec[1]), .i_evt_ffmt(pulse_vec[2]),
        .i_evt_pulse(pulse_vec[3]), .i_evt_orient(pulse_vec[4]), .i_evt_trans(pulse_vec[5]),
        .i_evt_fifo(pulse_vec[6]), .i_fifo_trig_mode(trig_mode), .i_fifo_empty(pulse_vec[11]),
        .i_gate_err(pulse_vec[7]), .i_odr_tick(pulse_vec[8]), .i_active(active),
        .i_inact_expired(pulse_vec[9]), .i_wake_evt(pulse_vec[10]),
        .o_fifo_gate(fifo_gate), .o_odr_low(odr_low), .o_sys_mode(sys_mode)
    );

    host_model u_host (
        .i_clock(clock), .i_rdata(rdata), .i_hit(hit),
        .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    function automatic logic [7:0] clr_addr(input int b);
        case (b)
            1: return `ADDR_INT_SRC;
            2: return `ADDR_FFMT_SRC;
            3: return `ADDR_PULSE_SRC;
            4: return `ADDR_ORIENT_STAT;
            5: return `ADDR_TRANS_SRC;
            default: return `ADDR_FIFO_STATUS;
        endcase
    endfunction : clr_addr

    task automatic pulse(input int b);
        @(posedge clock) pulse_vec[b] <= 1'b1;
        @(posedge clock) pulse_vec[b] <= 1'b0;
        #1;
    endtask : pulse

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       h;
        u_host.reg_read(a, d, h);
        `CHECK(d, exp)
        `CHECK(h, (a inside {8'h0A, 8'h0B, 8'h0C}))
    endtask : chk_reg

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #5_000_000;
        n_fail++;
        print_verdict();
    end

    initial begin
        int         other;
        logic [7:0] d;
        logic       h;
        n_fail = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        pulse_vec = 12'h000;
        trig_mode = 1'b0;
        active = 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        chk_reg(`ADDR_TRIG_CFG, `TRIG_CFG_RST);
        chk_reg(`ADDR_SYS_MODE, 8'h00);
        chk_reg(`ADDR_INT_SRC, `INT_SRC_RST);
        chk_reg(8'h0D, 8'h00);
        u_host.reg_write(`ADDR_SYS_MODE, 8'hFF);
        chk_reg(`ADDR_SYS_MODE, 8'h00);
        for (int b = 1; b <= 6; b++) begin
            pulse(b);
            chk_reg(`ADDR_INT_SRC, 8'h01 << b);
            chk_reg(`ADDR_TRIG_CFG, 8'h00);
            chk_reg(`ADDR_INT_SRC, (b == `SRC_VECM) ? 8'h00 : 8'h01 << b);
            u_host.reg_read(clr_addr(b), d, h);
            chk_reg(`ADDR_INT_SRC, 8'h00);
        end
        // data-ready clears only once all three axes have been read
        pulse(`SRC_DRDY);
        chk_reg(`ADDR_OUT_X_HI, 8'h00);
        chk_reg(`ADDR_OUT_Z_HI, 8'h00);
        chk_reg(`ADDR_INT_SRC, 8'h01);
        chk_reg(`ADDR_OUT_Y_HI, 8'h00);
        chk_reg(`ADDR_INT_SRC, 8'h00);
        @(posedge clock) active <= 1'b1;
        repeat (2) @(posedge clock);
        #1 `CHECK(sys_mode, `MODE_WAKE)
        chk_reg(`ADDR_INT_SRC, 8'h00);
        pulse(9);
        `CHECK({odr_low, sys_mode}, {1'b1, `MODE_SLEEP})
        chk_reg(`ADDR_INT_SRC, 8'h80);
        chk_reg(`ADDR_SYS_MODE, {6'h00, `MODE_SLEEP});
        chk_reg(`ADDR_INT_SRC, 8'h00);
        pulse(10);
        `CHECK({odr_low, sys_mode}, {1'b0, `MODE_WAKE})
        chk_reg(`ADDR_INT_SRC, 8'h80);
        chk_reg(`ADDR_SYS_MODE, {6'h00, `MODE_WAKE});
        chk_reg(`ADDR_INT_SRC, 8'h00);
        // a disabled source must not gate; the enabled one must
        for (int b = 1; b <= 5; b++) begin
            other = (b == 1) ? 2 : 1;
            u_host.reg_write(`ADDR_TRIG_CFG, 8'h01 << b);
            chk_reg(`ADDR_TRIG_CFG, 8'h01 << b);
            @(posedge clock) trig_mode <= 1'b1;
            pulse(other);
            `CHECK(fifo_gate, 1'b0)
            pulse(b);
            `CHECK(fifo_gate, 1'b1)
            @(posedge clock) trig_mode <= 1'b0;
            @(posedge clock);
            #1 `CHECK(fifo_gate, 1'b0)
            u_host.reg_read(clr_addr(b), d, h);
            u_host.reg_read(clr_addr(other), d, h);
        end
        chk_reg(`ADDR_INT_SRC, 8'h00);
        pulse(7);
        repeat (3) pulse(8);
        chk_reg(`ADDR_SYS_MODE, {1'b1, 5'h03, `MODE_WAKE});
        pulse(11);
        chk_reg(`ADDR_SYS_MODE, {1'b0, 5'h00, `MODE_WAKE});
        pulse(7);
        repeat (34) pulse(8);
        chk_reg(`ADDR_SYS_MODE, {1'b1, `FGT_MAX, `MODE_WAKE});
        pulse(11);
        @(posedge clock) active <= 1'b0;
        chk_reg(`ADDR_SYS_MODE, 8'h00);
        print_verdict();
    end
endmodule : event_status_and_system_mode_bench
